// >>> hdl/ssr_stack_regs.sv
// Purpose: Sequencer stack entries one to three with the stack pointer.
// Assumes: conv_done and outside_return come from logic on core_clk.
// Notes:   Entry zero and entries past three live outside this block.

// ****************************************************************
// Stack register top
// ****************************************************************
// Summary of operation
// - Frame bit 15 clear asks a read, set asks a write.
// - Frame bits 14 to 9 carry the target register address.
// - Return flag clear: step to the next entry after a conversion.
// - Return flag set: go back to entry zero after a conversion.
// - Bits 7 to 4 pick the converter B input channel.
// - Bits 3 to 0 pick the converter A input channel.
// - Entry at 0x22 resets to 0x4422.
// - Entry at 0x23 resets to 0x4633.
// - Entry at 0x21 resets to 0x4211.
module ssr_stack_regs
    import ssr_pkg::*;
#(
    parameter int STACK_DEPTH = 8
)
(
    // Clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           reset,
    // Register port
    input  wire logic [ADDR_W-1:0]              bus_addr,
    input  wire logic [WORD_W-1:0]              bus_wdata,
    input  wire logic                           bus_write,
    input  wire logic                           bus_read,
    output logic      [WORD_W-1:0]              bus_rdata,
    // Sequencer side
    input  wire logic                           conv_done,
    input  wire logic                           outside_return,
    output logic      [$clog2(STACK_DEPTH)-1:0] stack_pointer,
    output logic                                entry_held,
    output logic                                stack_wrap_control,
    output logic      [PICK_W-1:0]              converter_a_input_pick,
    output logic      [PICK_W-1:0]              converter_b_input_pick
);
    localparam int PTR_W = $clog2(STACK_DEPTH);

    // Pointer must reach every held entry and fit the status word
    if (STACK_DEPTH < ENTRY_LAST + 1 || PTR_W > CONTENT_W)
    begin : g_bad_depth
        $error("STACK_DEPTH out of the supported range");
    end

    // Map a register address to a held entry index, 0 if none
    function automatic logic [1:0] entry_index(input logic [ADDR_W-1:0] addr);
        if (addr == ENTRY_ONE_ADDR)
            return 2'(ENTRY_FIRST);
        else if (addr == ENTRY_TWO_ADDR)
            return 2'(ENTRY_FIRST + 1);
        else if (addr == ENTRY_THREE_ADDR)
            return 2'(ENTRY_LAST);
        else
            return NO_ENTRY;
    endfunction

    ssr_entry_if ent ();

    ssr_entry_bank u_bank (
        .core_clk (core_clk),
        .reset    (reset),
        .ent      (ent)
    );

    // ****************************************************************
    // Frame decode
    // ****************************************************************
    logic              frame_dir;
    logic [ADDR_W-1:0] frame_addr;
    logic              write_hit;
    logic              read_req;
    logic [ADDR_W-1:0] read_addr;
    logic [1:0]        wr_idx;

    // Write frames must name the same register the port addresses
    always_comb
    begin
        frame_dir  = bus_wdata[DIR_BIT];
        frame_addr = bus_wdata[ADDR_HI:ADDR_LO];
        wr_idx     = entry_index(bus_addr);
        write_hit  = bus_write && frame_dir == DIR_WRITE
                     && frame_addr == bus_addr && wr_idx != NO_ENTRY;
        read_req   = bus_read || (bus_write && frame_dir != DIR_WRITE);
        read_addr  = bus_read ? bus_addr : frame_addr;
    end

    assign ent.wr_en      = write_hit;
    assign ent.wr_idx     = wr_idx;
    assign ent.wr_content = bus_wdata[CONTENT_W-1:0];

    // ****************************************************************
    // Read data
    // ****************************************************************
    logic [WORD_W-1:0] rdata_reg;
    logic [WORD_W-1:0] rdata_next;
    logic [1:0]        rd_idx;
    logic [PTR_W-1:0]  ptr_reg;
    logic [PTR_W-1:0]  ptr_next;

    // Read word echoes the address; data stands one cycle only
    always_comb
    begin
        rd_idx     = entry_index(read_addr);
        rdata_next = '0;
        if (read_req)
        begin
            if (read_addr == POINTER_ADDR)
                rdata_next = {1'b0, read_addr, CONTENT_W'(ptr_reg)};
            else if (rd_idx != NO_ENTRY)
                rdata_next = {1'b0, read_addr, ent.content[rd_idx]};
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            rdata_reg <= '0;
        else
            rdata_reg <= rdata_next;
    end

    assign bus_rdata = rdata_reg;

    // ****************************************************************
    // Stack pointer
    // ****************************************************************
    logic                 held_now;
    logic [1:0]           held_idx;
    logic [CONTENT_W-1:0] cur_content;
    logic                 cur_return;

    // Entries outside this block report their flag on outside_return
    always_comb
    begin
        held_now    = ptr_reg >= PTR_W'(ENTRY_FIRST) && ptr_reg <= PTR_W'(ENTRY_LAST);
        held_idx    = held_now ? ptr_reg[1:0] : NO_ENTRY;
        cur_content = held_now ? ent.content[held_idx] : '0;
        cur_return  = held_now ? cur_content[WRAP_BIT] : outside_return;
    end

    // One move per finished conversion; last entry wraps to zero
    always_comb
    begin
        ptr_next = ptr_reg;
        if (conv_done)
        begin
            if (cur_return)
                ptr_next = '0;
            else if (ptr_reg == PTR_W'(STACK_DEPTH - 1))
                ptr_next = '0;
            else
                ptr_next = ptr_reg + PTR_W'(1);
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            ptr_reg <= '0;
        else
            ptr_reg <= ptr_next;
    end

    // ****************************************************************
    // Current entry outputs
    // ****************************************************************
    logic              held_reg;
    logic              held_next;
    logic              wrap_reg;
    logic              wrap_next;
    logic [PICK_W-1:0] pick_a_reg;
    logic [PICK_W-1:0] pick_a_next;
    logic [PICK_W-1:0] pick_b_reg;
    logic [PICK_W-1:0] pick_b_next;

    // Registered copy of the current entry; trails the pointer by a cycle
    always_comb
    begin
        held_next   = held_now;
        wrap_next   = cur_return;
        pick_b_next = cur_content[PICK_B_HI:PICK_B_LO];
        pick_a_next = cur_content[PICK_A_HI:PICK_A_LO];
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            held_reg   <= 1'b0;
            wrap_reg   <= 1'b0;
            pick_a_reg <= '0;
            pick_b_reg <= '0;
        end
        else
        begin
            held_reg   <= held_next;
            wrap_reg   <= wrap_next;
            pick_a_reg <= pick_a_next;
            pick_b_reg <= pick_b_next;
        end
    end

    assign stack_pointer          = ptr_reg;
    assign entry_held             = held_reg;
    assign stack_wrap_control     = wrap_reg;
    assign converter_a_input_pick = pick_a_reg;
    assign converter_b_input_pick = pick_b_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_done_stay;
        conv_done && !cur_return && ptr_reg != PTR_W'(STACK_DEPTH - 1);
    endsequence

    sequence s_done_wrap;
        conv_done && cur_return;
    endsequence

    a_read_frame_keeps : assert property (
        bus_write && !frame_dir |=> $stable(ent.content))
        else $error("read frame changed a stack entry");

    a_write_frame_stores : assert property (
        write_hit |=> ent.content[$past(wr_idx)] == $past(bus_wdata[CONTENT_W-1:0]))
        else $error("write frame not stored");

    a_addr_mismatch_ignored : assert property (
        bus_write && frame_addr != bus_addr && !bus_read |=> $stable(ent.content))
        else $error("frame with wrong address changed an entry");

    a_read_echoes_addr : assert property (
        read_req && rd_idx != NO_ENTRY |=> bus_rdata[ADDR_HI:ADDR_LO] == $past(read_addr))
        else $error("read word does not echo the register address");

    a_step_next_entry : assert property (
        s_done_stay |=> ptr_reg == $past(ptr_reg) + PTR_W'(1))
        else $error("pointer did not step to the next entry");

    a_return_to_first : assert property (
        s_done_wrap |=> ptr_reg == '0 ##1 (ptr_reg == '0 || $past(conv_done)))
        else $error("pointer did not return to entry zero");

    a_pick_b_follows : assert property (
        held_now |=> converter_b_input_pick == $past(ent.content[held_idx][PICK_B_HI:PICK_B_LO]))
        else $error("converter B pick does not follow the entry");

    a_pick_a_follows : assert property (
        held_now && $stable(ptr_reg) |=> converter_a_input_pick == $past(cur_content[PICK_A_HI:PICK_A_LO]))
        else $error("converter A pick does not follow the entry");

    a_pointer_holds : assert property (
        !conv_done |=> ptr_reg == $past(ptr_reg))
        else $error("pointer moved without a finished conversion");
endmodule // ssr_stack_regs

// >>> hdl/ssr_pkg.sv
// Purpose: Shared constants for the sequencer stack entry registers.
// Assumes: 16-bit register frames, 6-bit register addresses.
// Notes:   Entry content is the low nine bits of a frame (return flag and picks).

// ****************************************************************
// Constants
// ****************************************************************
package ssr_pkg;
    localparam int ADDR_W    = 6;
    localparam int WORD_W    = 16;
    localparam int CONTENT_W = 9;
    localparam int PICK_W    = 4;

    // Frame field positions
    localparam int DIR_BIT      = 15;
    localparam int ADDR_HI      = 14;
    localparam int ADDR_LO      = 9;
    localparam int WRAP_BIT     = 8;
    localparam int PICK_B_HI    = 7;
    localparam int PICK_B_LO    = 4;
    localparam int PICK_A_HI    = 3;
    localparam int PICK_A_LO    = 0;
    localparam logic DIR_WRITE  = 1'b1;

    // Register addresses
    localparam logic [ADDR_W-1:0] ENTRY_ONE_ADDR   = 6'h21;
    localparam logic [ADDR_W-1:0] ENTRY_TWO_ADDR   = 6'h22;
    localparam logic [ADDR_W-1:0] ENTRY_THREE_ADDR = 6'h23;
    localparam logic [ADDR_W-1:0] POINTER_ADDR     = 6'h30;

    // Held entries and their reset words
    localparam int ENTRY_FIRST = 1;
    localparam int ENTRY_LAST  = 3;
    localparam logic [WORD_W-1:0] ENTRY_ONE_RST   = 16'h4211;
    localparam logic [WORD_W-1:0] ENTRY_TWO_RST   = 16'h4422;
    localparam logic [WORD_W-1:0] ENTRY_THREE_RST = 16'h4633;

    // Index 0 means no held entry
    localparam logic [1:0] NO_ENTRY = 2'h0;
endpackage

// >>> hdl/ssr_entry_if.sv
// Purpose: Carrier between the stack register top and its entry storage.
// Assumes: One clock domain.
// Notes:   Entry words are indexed 1 to 3; index 0 is never stored.

// ****************************************************************
// Entry storage carrier
// ****************************************************************
interface ssr_entry_if;
    import ssr_pkg::*;
    logic                                  wr_en;
    logic [1:0]                            wr_idx;
    logic [CONTENT_W-1:0]                  wr_content;
    logic [ENTRY_LAST:ENTRY_FIRST][CONTENT_W-1:0] content;

    modport store (input wr_en, input wr_idx, input wr_content, output content);
    modport ctrl  (output wr_en, output wr_idx, output wr_content, input content);
endinterface

// >>> hdl/ssr_entry_bank.sv
// Purpose: Flip-flop storage for stack entries one to three.
// Assumes: Writes are already decoded to an entry index.
// Notes:   Reset content is the low bits of each documented reset word.

// ****************************************************************
// Entry storage
// ****************************************************************
module ssr_entry_bank
    import ssr_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset,
    // Storage side of the carrier
    ssr_entry_if.store ent
);
    localparam logic [WORD_W-1:0] RST_WORD [ENTRY_FIRST:ENTRY_LAST] =
        '{ENTRY_ONE_RST, ENTRY_TWO_RST, ENTRY_THREE_RST};

    logic boot_reg;
    logic boot_next;

    // First cycle after reset release, for the reset checks
    always_comb boot_next = 1'b0;
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            boot_reg <= 1'b1;
        else
            boot_reg <= boot_next;
    end

    // ****************************************************************
    // One register per entry
    // ****************************************************************
    for (genvar i = ENTRY_FIRST; i <= ENTRY_LAST; i++)
    begin : g_entry
        logic [CONTENT_W-1:0] word_reg;
        logic [CONTENT_W-1:0] word_next;

        // Load only on a decoded write to this index
        always_comb
        begin
            word_next = word_reg;
            if (ent.wr_en && ent.wr_idx == 2'(i))
                word_next = ent.wr_content;
        end

        // Reset values of the three entries
        always_ff @(posedge core_clk or posedge reset)
        begin
            if (reset)
                word_reg <= RST_WORD[i][CONTENT_W-1:0];
            else
                word_reg <= word_next;
        end

        assign ent.content[i] = word_reg;

        a_entry_reset_value : assert property (@(posedge core_clk) disable iff (reset)
            boot_reg |-> word_reg == RST_WORD[i][CONTENT_W-1:0])
            else $error("stack entry not at its reset value after reset");
    end
endmodule // ssr_entry_bank

// >>> bench/tb_ssr_stack_regs.sv
// Purpose: Self-checking bench for the sequencer stack entry registers.
// Assumes: Register port strobes sampled on core_clk; read data one cycle later.
// Notes:   Reference model holds entry content and pointer; seed is fixed.

// ****************************************************************
// Testbench top
// ****************************************************************
module tb_ssr_stack_regs
    import ssr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DEPTH = 8;

    logic                  core_clk;
    logic                  reset;
    logic [ADDR_W-1:0]     bus_addr;
    logic [WORD_W-1:0]     bus_wdata;
    logic                  bus_write;
    logic                  bus_read;
    logic [WORD_W-1:0]     bus_rdata;
    logic                  conv_done;
    logic                  outside_return;
    logic [2:0]            stack_pointer;
    logic                  entry_held;
    logic                  stack_wrap_control;
    logic [PICK_W-1:0]     converter_a_input_pick;
    logic [PICK_W-1:0]     converter_b_input_pick;
    int                    fail_count;
    int                    compares;
    integer                seed;
    logic [CONTENT_W-1:0]  ent [1:3];
    int                    ptr;

    ssr_stack_regs #(.STACK_DEPTH(DEPTH)) u_ssr_stack_regs
    (
        .core_clk               (core_clk),
        .reset                  (reset),
        .bus_addr               (bus_addr),
        .bus_wdata              (bus_wdata),
        .bus_write              (bus_write),
        .bus_read               (bus_read),
        .bus_rdata              (bus_rdata),
        .conv_done              (conv_done),
        .outside_return         (outside_return),
        .stack_pointer          (stack_pointer),
        .entry_held             (entry_held),
        .stack_wrap_control     (stack_wrap_control),
        .converter_a_input_pick (converter_a_input_pick),
        .converter_b_input_pick (converter_b_input_pick)
    );

    // 125 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ****************************************************************
    // Reference model
    // ****************************************************************
    // Word a read of this address should return
    function automatic logic [15:0] word_of(input logic [5:0] a);
        if (a >= ENTRY_ONE_ADDR && a <= ENTRY_THREE_ADDR)
            return {1'b0, a, ent[int'(a) - 32]};
        if (a == POINTER_ADDR)
            return {1'b0, a, 6'h00, 3'(ptr)};
        return 16'h0000;
    endfunction

    // Pointer after one finished conversion
    function automatic int next_ptr(input logic ext);
        logic flag;
        flag = (ptr >= 1 && ptr <= 3) ? ent[ptr][WRAP_BIT] : ext;
        return flag ? 0 : (ptr + 1) % DEPTH;
    endfunction

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Read, then confirm the data word stands for one cycle only
    task automatic rd(input logic [5:0] a);
        @(posedge core_clk);
        bus_read <= 1'b1;
        bus_addr <= a;
        @(posedge core_clk);
        bus_read <= 1'b0;
        #1 check("bus_rdata", bus_rdata, word_of(a));
        @(posedge core_clk);
        #1 check("bus_rdata idle", bus_rdata, 16'h0000);
    endtask

    // Frame write; a clear direction bit must answer like a read
    task automatic wr(input logic [5:0] a, input logic [15:0] f);
        @(posedge core_clk);
        bus_write <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= f;
        @(posedge core_clk);
        bus_write <= 1'b0;
        if (!f[DIR_BIT])
            #1 check("frame read", bus_rdata, word_of(f[ADDR_HI:ADDR_LO]));
        else
        begin
            if (f[ADDR_HI:ADDR_LO] == a && a >= ENTRY_ONE_ADDR && a <= ENTRY_THREE_ADDR)
                ent[int'(a) - 32] = f[8:0];
            #1 check("write frame rdata", bus_rdata, 16'h0000);
        end
    endtask

    // One conversion end, then pointer and entry outputs
    task automatic conv(input logic ext);
        logic held;
        @(posedge core_clk);
        conv_done      <= 1'b1;
        outside_return <= ext;
        @(posedge core_clk);
        conv_done <= 1'b0;
        ptr = next_ptr(ext);
        #1 check("stack_pointer", 16'(stack_pointer), 16'(ptr));
        @(posedge core_clk);
        #1 held = (ptr >= 1 && ptr <= 3);
        check("entry_held", 16'(entry_held), 16'(held));
        check("pick a", 16'(converter_a_input_pick), held ? 16'(ent[ptr][3:0]) : 16'h0000);
        check("pick b", 16'(converter_b_input_pick), held ? 16'(ent[ptr][7:4]) : 16'h0000);
        check("wrap flag", 16'(stack_wrap_control), held ? 16'(ent[ptr][WRAP_BIT]) : 16'(ext));
    endtask

    // Reset for four cycles; model back to reset words
    task automatic do_reset;
        reset <= 1'b1;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        ent[1] = ENTRY_ONE_RST[8:0];
        ent[2] = ENTRY_TWO_RST[8:0];
        ent[3] = ENTRY_THREE_RST[8:0];
        ptr = 0;
        #1 check("pointer after reset", 16'(stack_pointer), 16'h0000);
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Hang guard, well beyond the 1200 or so cycles needed
    initial
    begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        conclude();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [15:0] f;
        logic [5:0]  a;
        reset = 1'b1;
        bus_addr = 6'h00;
        bus_wdata = 16'h0000;
        bus_write = 1'b0;
        bus_read = 1'b0;
        conv_done = 1'b0;
        outside_return = 1'b0;
        fail_count = 0;
        compares = 0;
        seed = 89124;
        do_reset();
        rd(ENTRY_ONE_ADDR);
        rd(ENTRY_TWO_ADDR);
        rd(ENTRY_THREE_ADDR);
        rd(POINTER_ADDR);
        rd(6'h3f);
        $display("Test reset values finished");
        // Direction and address fields; refused writes leave entries alone
        wr(ENTRY_TWO_ADDR, {1'b0, ENTRY_THREE_ADDR, 9'h000});
        wr(ENTRY_TWO_ADDR, {1'b1, ENTRY_THREE_ADDR, 9'h1ff});
        wr(ENTRY_ONE_ADDR, {1'b0, ENTRY_ONE_ADDR, 9'h155});
        wr(POINTER_ADDR, {1'b1, POINTER_ADDR, 9'h1ff});
        wr(ENTRY_TWO_ADDR, {1'b1, ENTRY_TWO_ADDR, 9'h1a3});
        for (int i = 1; i <= 3; i++)
            rd(6'(32 + i));
        $display("Test frame decoding finished");
        // Clear return flags, walk the whole stack and wrap past the top
        for (int i = 1; i <= 3; i++)
            wr(6'(32 + i), {1'b1, 6'(32 + i), 1'b0, 4'(i + 8), 4'(15 - i)});
        repeat (DEPTH) conv(1'b0);
        conv(1'b1);
        wr(ENTRY_THREE_ADDR, {1'b1, ENTRY_THREE_ADDR, 9'h1c7});
        repeat (4) conv(1'b0);
        $display("Test stack walk finished");
        // Random mix of writes, reads and conversions
        repeat (400)
        begin
            a = 6'h20 + 6'($unsigned($random(seed)) % 4);
            f = 16'($random(seed));
            case ($unsigned($random(seed)) % 4)
                0:
                begin
                    if (f[10])
                        f[15:9] = {1'b1, a};
                    wr(a, f);
                end
                1: rd(f[0] ? POINTER_ADDR : a);
                default: conv(f[3]);
            endcase
        end
        $display("Test random traffic finished");
        // Reset in mid-run restores words and pointer
        conv(1'b0);
        @(posedge core_clk);
        do_reset();
        for (int i = 1; i <= 3; i++)
            rd(6'(32 + i));
        conv(1'b0);
        $display("Test mid-run reset finished");
        conclude();
    end
endmodule // tb_ssr_stack_regs
